// file: src/sep_host.v
// Host-side SPI controller for a serial EEPROM with protectable status.
// Assumes an APB master on mclk and a device on cs/sck/si/so/wp pins.
`timescale 1ns/10ps
`include "sep_defines.vh"
module sep_host (
   input  wire        mclk,
   input  wire        srst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output reg         cs_n,
   output reg         sck,
   output reg         si,
   input  wire        so,
   output reg         wp_n
);
   // Frame sequencer: IDLE waits for a go order, LOW and HIGH are the two
   // halves of each serial bit, END keeps select low for one more half bit,
   // GAP keeps select high between frames, and DONE drops busy one cycle
   // later, so a status poll never sees idle before select is back up and
   // the next order always starts a fresh selection.
   localparam [5:0] S_IDLE = 6'b000001;
   localparam [5:0] S_LOW  = 6'b000010;
   localparam [5:0] S_HIGH = 6'b000100;
   localparam [5:0] S_END  = 6'b001000;
   localparam [5:0] S_GAP  = 6'b010000;
   localparam [5:0] S_DONE = 6'b100000;

   // Half bit and select-high counts for the 8-bit link timer
   // Cutting to 8 bits is safe: both counts are far below 256
   localparam [31:0] HALF_CYC_W = `SEP_HALF_CYC;
   localparam [31:0] CSH_CYC_W  = `SEP_CSH_CYC;
   localparam [7:0]  HALF_CYC   = HALF_CYC_W[7:0];
   localparam [7:0]  CSH_CYC    = CSH_CYC_W[7:0];

   reg [5:0]  st_r;
   reg [2:0]  op_r;
   reg [5:0]  cnt_r;
   reg [15:0] addr_r;
   reg [31:0] wdata_r;
   reg [31:0] rdata_r;
   reg [7:0]  shout_r;
   reg [7:0]  shin_r;
   reg [2:0]  bit_r;
   reg [1:0]  phase_r;
   reg [5:0]  byte_r;
   reg [7:0]  tmr_r;
   reg        busy_r;
   reg        so_s1_r;
   reg        so_s2_r;
   reg [31:0] prdata_r;

   wire wr_en = psel & penable & pwrite;
   // Reads are decoded in the setup cycle; see the read data capture below
   wire rd_en = psel & ~penable & ~pwrite;
   wire tick  = (tmr_r == 8'h00);
   wire       go    = wr_en & (paddr == `SEP_OFF_CTRL) & pwdata[`SEP_CTRL_GO];
   wire [2:0] go_op = pwdata[`SEP_CTRL_OP_MSB:`SEP_CTRL_OP_LSB];

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = prdata_r;

   // Instruction byte for the chosen operation
   function [7:0] ins_of;
      input [2:0] op;
      begin
         case (op)
            `SEP_OP_CMD_WRITE_ENABLE:  ins_of = `SEP_INS_CMD_WRITE_ENABLE;
            `SEP_OP_CMD_WRITE_DISABLE:  ins_of = `SEP_INS_CMD_WRITE_DISABLE;
            `SEP_OP_SFLAG: ins_of = `SEP_INS_SFLAG;
            `SEP_OP_RSTAT: ins_of = `SEP_INS_RSTAT;
            `SEP_OP_WSTAT: ins_of = `SEP_INS_WSTAT;
            `SEP_OP_READ:  ins_of = `SEP_INS_READ;
            default:       ins_of = `SEP_INS_WRITE;
         endcase
      end
   endfunction

   // Status byte as sent: bits 5,4 forced high, bits 1,0 forced low
   function [7:0] stat_byte;
      input [7:0] raw;
      begin
         stat_byte = (raw & `SEP_WSTAT_MASK) | `SEP_WSTAT_ONES;
      end
   endfunction

   // Next byte to send: phase 0 address high byte, phase 1 address low byte, otherwise data top byte
   reg [7:0] nxt_byte;
   always @* begin
      case (phase_r)
         2'd0:    nxt_byte = addr_r[15:8];
         2'd1:    nxt_byte = addr_r[7:0];
         default: nxt_byte = wdata_r[31:24];
      endcase
   end

   wire has_addr = (op_r == `SEP_OP_READ) | (op_r == `SEP_OP_WRITE);
   wire has_data = has_addr | (op_r == `SEP_OP_WSTAT) | (op_r == `SEP_OP_RSTAT);

   // Read data is captured in the setup cycle, so it already stands at the
   // zero-wait access edge where the master takes it
   reg [31:0] rd_mux;
   always @* begin
      case (paddr)
         `SEP_OFF_CTRL:  rd_mux = {18'h0, cnt_r, 4'h0, op_r, 1'b0};
         `SEP_OFF_ADDR:  rd_mux = {16'h0, addr_r};
         `SEP_OFF_WDATA: rd_mux = wdata_r;
         `SEP_OFF_RDATA: rd_mux = rdata_r;
         `SEP_OFF_STAT:  rd_mux = {31'h0, busy_r};
         `SEP_OFF_WPCTL: rd_mux = {31'h0, wp_n};
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge mclk) begin
      if (srst) begin
         prdata_r <= 32'h0000_0000;
         wp_n     <= `SEP_RST_WPCTL;
      end else begin
         if (rd_en)
            prdata_r <= rd_mux;
         // The pin follows software at once, even mid-frame; the device
         // itself lets a running status write finish
         if (wr_en && paddr == `SEP_OFF_WPCTL)
            wp_n <= pwdata[0];
      end
   end

   // Device output crosses into mclk through two flops
   always @(posedge mclk) begin
      if (srst) begin
         so_s1_r <= 1'b0;
         so_s2_r <= 1'b0;
      end else begin
         so_s1_r <= so;
         so_s2_r <= so_s1_r;
      end
   end

   always @(posedge mclk) begin
      if (srst) begin
         st_r     <= S_IDLE;
         op_r     <= 3'h0;
         cnt_r    <= 6'h00;
         addr_r   <= 16'h0000;
         wdata_r  <= 32'h0000_0000;
         rdata_r  <= 32'h0000_0000;
         shout_r  <= 8'h00;
         shin_r   <= 8'h00;
         bit_r    <= 3'h0;
         phase_r  <= 2'd0;
         byte_r   <= 6'h00;
         tmr_r    <= 8'h00;
         busy_r   <= 1'b0;
         cs_n     <= 1'b1;
         sck      <= 1'b0;
         si       <= 1'b0;
      end else begin
         // Orders are frozen while a frame runs, so no byte changes mid-shift
         if (wr_en && !busy_r) begin
            case (paddr)
               `SEP_OFF_ADDR:  addr_r  <= pwdata[15:0] & `SEP_ADDR_MASK;
               `SEP_OFF_WDATA: wdata_r <= pwdata;
               default: ;
            endcase
         end
         if (tmr_r != 8'h00)
            tmr_r <= tmr_r - 8'h01;
         case (st_r)
            S_IDLE: begin
               if (go) begin
                  op_r    <= go_op;
                  cnt_r   <= pwdata[`SEP_CTRL_CNT_MSB:`SEP_CTRL_CNT_LSB];
                  shout_r <= ins_of(go_op);
                  busy_r  <= 1'b1;
                  cs_n    <= 1'b0;
                  sck     <= 1'b0;
                  bit_r   <= 3'h0;
                  phase_r <= 2'd0;
                  byte_r  <= 6'h00;
                  rdata_r <= 32'h0000_0000;
                  tmr_r   <= HALF_CYC;
                  st_r    <= S_LOW;
               end
            end
            S_LOW: begin
               si <= shout_r[7];
               if (tick) begin
                  sck   <= 1'b1;
                  tmr_r <= HALF_CYC;
                  st_r  <= S_HIGH;
               end
            end
            S_HIGH: begin
               if (tick) begin
                  // Sample as the device edge has long settled
                  shin_r  <= {shin_r[6:0], so_s2_r};
                  shout_r <= {shout_r[6:0], 1'b0};
                  sck     <= 1'b0;
                  tmr_r   <= HALF_CYC;
                  bit_r   <= bit_r + 3'h1;
                  st_r    <= S_LOW;
                  if (bit_r == 3'h7) begin
                     // Byte boundary: select may rise only here
                     if (byte_r == 6'h00 && !has_data) begin
                        st_r <= S_END;
                     end else if (byte_r == 6'h00 && !has_addr) begin
                        byte_r  <= 6'h01;
                        phase_r <= 2'd3;
                        if (op_r == `SEP_OP_WSTAT)
                           shout_r <= stat_byte(wdata_r[31:24]);
                        else
                           shout_r <= 8'h00;
                     end else if (byte_r == 6'h00) begin
                        byte_r  <= 6'h01;
                        shout_r <= nxt_byte;
                        phase_r <= 2'd1;
                     end else if (phase_r == 2'd1) begin
                        shout_r <= nxt_byte;
                        phase_r <= 2'd3;
                     end else begin
                        // Data byte or address low byte complete
                        if (phase_r == 2'd3 && byte_r != 6'h01 || !has_addr) begin
                           rdata_r <= {rdata_r[23:0], shin_r[6:0], so_s2_r};
                        end
                        if (phase_r == 2'd3 && has_addr && byte_r == 6'h01) begin
                           byte_r <= 6'h02;
                           if (op_r == `SEP_OP_WRITE) begin
                              // Address done: the first data byte is the top of the word
                              shout_r <= nxt_byte;
                           end else begin
                              shout_r <= 8'h00;
                           end
                        end else if (cnt_r == 6'h00) begin
                           st_r <= S_END;
                        end else begin
                           cnt_r <= cnt_r - 6'h01;
                           if (op_r == `SEP_OP_WRITE) begin
                              // Page wrap is the device's; host only streams
                              wdata_r <= {wdata_r[23:0], 8'h00};
                              shout_r <= wdata_r[23:16];
                           end else begin
                              shout_r <= 8'h00;
                           end
                        end
                     end
                  end
               end
            end
            S_END: begin
               if (tick) begin
                  cs_n  <= 1'b1;
                  si    <= 1'b0;
                  tmr_r <= CSH_CYC;
                  st_r  <= S_GAP;
               end
            end
            S_GAP: begin
               if (tick)
                  st_r <= S_DONE;
            end
            S_DONE: begin
               busy_r <= 1'b0;
               st_r   <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule // sep_host

// file: src/sep_defines.vh
// Constants for the serial EEPROM host controller: APB map, opcodes,
// status bit positions and serial timing. Included by the controller only.
`ifndef SEP_DEFINES_VH
`define SEP_DEFINES_VH
// APB register offsets (byte addresses)
`define SEP_OFF_CTRL      12'h000
`define SEP_OFF_ADDR      12'h004
`define SEP_OFF_WDATA     12'h008
`define SEP_OFF_RDATA     12'h00C
`define SEP_OFF_STAT      12'h010
`define SEP_OFF_WPCTL     12'h014
// Control register fields
`define SEP_CTRL_GO       0
`define SEP_CTRL_OP_LSB   1
`define SEP_CTRL_OP_MSB   3
`define SEP_CTRL_CNT_LSB  8
`define SEP_CTRL_CNT_MSB  13
// Operation codes written to the control register
`define SEP_OP_CMD_WRITE_ENABLE       3'h0
`define SEP_OP_CMD_WRITE_DISABLE       3'h1
`define SEP_OP_SFLAG      3'h2
`define SEP_OP_RSTAT      3'h3
`define SEP_OP_WSTAT      3'h4
`define SEP_OP_READ       3'h5
`define SEP_OP_WRITE      3'h6
// Device instruction bytes, shifted MSB first
`define SEP_INS_CMD_WRITE_ENABLE      8'h06
`define SEP_INS_SFLAG     8'h00
`define SEP_INS_CMD_WRITE_DISABLE      8'h04
`define SEP_INS_RSTAT     8'h05
`define SEP_INS_WSTAT     8'h01
`define SEP_INS_READ      8'h03
`define SEP_INS_WRITE     8'h02
// Device status bit positions
`define SEP_ST_PROT_EN    7
`define SEP_ST_UFLAG      6
`define SEP_ST_RP_HI      3
`define SEP_ST_RP_LO      2
`define SEP_ST_WLATCH     1
`define SEP_ST_BUSY       0
// Bits 5 and 4 are forced to one, bits 1 and 0 to zero on a status write
`define SEP_WSTAT_MASK    8'hCC
`define SEP_WSTAT_ONES    8'h30
// Address bits used by the array; upper bits sent as zero
`define SEP_ADDR_MASK     16'h0FFF
// Serial clock: half period in ns, cycles derived from the 10 ns clock
`define SEP_HALF_NS       250
`define SEP_CLK_NS        10
`define SEP_HALF_CYC      (`SEP_HALF_NS / `SEP_CLK_NS)
// Chip select high time between frames, ns and cycles (rounded up)
`define SEP_CSH_NS        500
`define SEP_CSH_CYC       ((`SEP_CSH_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)
// Reset values
`define SEP_RST_CTRL      32'h0000_0000
`define SEP_RST_WPCTL     1'b1
`endif

// file: verification/sep_host_assertions.sv
// Port-level checks for the serial EEPROM host controller.
// Bound to sep_host from the bench top; single mclk domain.
`timescale 1ns/10ps
module sep_host_assertions (
   input wire        mclk,
   input wire        srst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        pslverr,
   input wire        cs_n,
   input wire        sck,
   input wire        si,
   input wire        wp_n
);
   logic [2:0] bit_cnt_r;
   // Rising sck edges seen in the current frame, modulo one byte
   always @(posedge mclk) begin
      if (srst || cs_n) bit_cnt_r <= 3'h0;
      else if ($rose(sck)) bit_cnt_r <= bit_cnt_r + 3'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   chk_rst_idle: assert property ($past(srst) |-> cs_n && !sck && wp_n)
      else $error("pins not idle after reset");
   chk_sck_in_frame: assert property (cs_n |-> !sck)
      else $error("sck high outside a frame");
   chk_si_hold: assert property ($rose(sck) |-> $stable(si))
      else $error("si changed at sck rise");
   chk_sck_high: assert property ($rose(sck) |-> ##26 $fell(sck))
      else $error("sck high time wrong");
   chk_cs_lead: assert property ($fell(cs_n) |-> !sck [*8])
      else $error("sck moved at select fall");
   chk_cs_gap: assert property ($rose(cs_n) |-> cs_n [*8])
      else $error("select high gap too short");
   chk_byte_frame: assert property ($rose(cs_n) |-> bit_cnt_r == 3'h0)
      else $error("select rose inside a byte");
   chk_apb_ready: assert property (psel && penable |-> pready && !pslverr)
      else $error("apb answer wrong");
   chk_wp_pin: assert property (psel && penable && pwrite && paddr == 12'h014 |=>
      wp_n == $past(pwdata[0]))
      else $error("wp_n not following control");
   cover property ($rose(cs_n));
   cover property ($fell(wp_n));
   cover property (psel && penable && pwrite && paddr == 12'h000);
endmodule // sep_host_assertions

// file: verification/sep_dev_model.sv
// Behavioural serial EEPROM with protectable status register.
// Driven by the host pins; so never floats, it toggles when released.
`timescale 1ns/10ps
module sep_dev_model #(
   parameter int TWC_NS = 20000
) (
   input  wire  cs_n,
   input  wire  sck,
   input  wire  si,
   input  wire  wp_n,
   output logic so
);
   logic [7:0]  mem [0:4095];
   logic [31:0] sh;
   logic [7:0]  op, nsr, pd [$];
   logic [11:0] a, pa [$];
   logic [1:0]  bp;
   logic        pe, flg, write_latch_flag, busy;
   int          n;
   wire  [7:0]  st = {pe, flg, 2'b11, bp, write_latch_flag, busy};
   function automatic bit prot(input logic [11:0] x);
      return bp == 2'h3 || (bp == 2'h2 && x >= 12'h800) || (bp == 2'h1 && x >= 12'hC00);
   endfunction
   initial begin
      {pe, flg, write_latch_flag, busy, bp, n, op, so} = '0;
      foreach (mem[i]) mem[i] = i[7:0];
   end
   always @(posedge sck) if (!cs_n) begin
      sh = {sh[30:0], si};
      n++;
      // Only a status read is heard while a write cycle runs
      if (n == 8) op = (busy && sh[7:0] != 8'h05) ? 8'hFF : sh[7:0];
      if (n == 16) nsr = sh[7:0];
      if (n == 24) a = sh[11:0];
      if (op == 8'h02 && n >= 32 && n % 8 == 0) begin
         pa.push_back({a[11:5], a[4:0] + 5'((n - 32) / 8)});
         pd.push_back(sh[7:0]);
      end
   end
   always @(negedge sck)
      if (!cs_n && op == 8'h05 && n >= 8) so <= st[7 - n % 8];
      else if (!cs_n && op == 8'h03 && n >= 24) so <= mem[a + 12'((n - 24) / 8)][7 - n % 8];
      else so <= ~so;
   always @(posedge cs_n) begin
      so <= ~so;
      case (op)
         8'h06: if (n == 8) write_latch_flag = 1'b1;
         8'h04: if (n == 8) {write_latch_flag, flg} = 2'b00;
         8'h00: if (n == 8) flg = 1'b1;
         8'h01: if (n == 16 && write_latch_flag && !(pe && !wp_n) && (nsr & 8'h33) == 8'h30) begin
            {pe, bp} = {nsr[7], nsr[3:2]};
            {write_latch_flag, busy} = 2'b01;
            busy <= #(TWC_NS) 1'b0;
         end
         8'h02: if (n >= 32 && n % 8 == 0 && write_latch_flag) begin
            foreach (pa[i]) if (!prot(pa[i])) mem[pa[i]] = pd[i];
            {write_latch_flag, busy} = 2'b01;
            busy <= #(TWC_NS) 1'b0;
         end
         default: ;
      endcase
      n = 0;
      pa.delete();
      pd.delete();
   end
endmodule // sep_dev_model

// file: verification/sep_host_tb_top.sv
// Self-checking bench for sep_host: APB orders, device model on pins.
// Assumes sep_host, sep_dev_model and sep_host_assertions compiled.
`timescale 1ns/10ps
module sep_host_tb_top;
   typedef struct packed {
      logic [3:0]  op;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } sep_row_t;
   logic        mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rv;
   wire  [31:0] prdata;
   wire         pready, pslverr, cs_n, sck, si, wp_n, so;
   int          num_errors = 0, checks = 0;
   // Ops 0..6 go to the controller, 7 drives wp_n, 8 polls device busy
   sep_row_t    rows [] = '{
      '{4'h3, 12'h000, 32'h0, 32'h30}, '{4'h0, 12'h000, 32'h0, 32'h0},
      '{4'h3, 12'h000, 32'h0, 32'h32}, '{4'h2, 12'h000, 32'h0, 32'h0},
      '{4'h3, 12'h000, 32'h0, 32'h72}, '{4'h1, 12'h000, 32'h0, 32'h0},
      '{4'h3, 12'h000, 32'h0, 32'h30}, '{4'h5, 12'hFFE, 32'h0, 32'hFEFF0001},
      '{4'h6, 12'h01E, 32'h11223344, 32'h0}, '{4'h5, 12'h01E, 32'h0, 32'h1E1F2021},
      '{4'h0, 12'h000, 32'h0, 32'h0}, '{4'h6, 12'h01E, 32'h11223344, 32'h0},
      '{4'h3, 12'h000, 32'h0, 32'h31}, '{4'h8, 12'h000, 32'h0, 32'h0},
      '{4'h5, 12'h01E, 32'h0, 32'h11222021}, '{4'h0, 12'h000, 32'h0, 32'h0},
      '{4'h4, 12'h000, 32'h87000000, 32'h0}, '{4'h3, 12'h000, 32'h0, 32'hB5},
      '{4'h8, 12'h000, 32'h0, 32'h0}, '{4'h0, 12'h000, 32'h0, 32'h0},
      '{4'h6, 12'hC00, 32'h99999999, 32'h0}, '{4'h8, 12'h000, 32'h0, 32'h0},
      '{4'h5, 12'hBFF, 32'h0, 32'hFF000102},
      '{4'h7, 12'h000, 32'h0, 32'h0}, '{4'h0, 12'h000, 32'h0, 32'h0},
      '{4'h4, 12'h000, 32'h0, 32'h0},
      '{4'h3, 12'h000, 32'h0, 32'hB6}, '{4'h7, 12'h000, 32'h1, 32'h0},
      '{4'h4, 12'h000, 32'h0, 32'h0}, '{4'h3, 12'h000, 32'h0, 32'h31}};
   always #5 mclk = ~mclk;
   sep_host i_sep_host (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .wp_n(wp_n));
   sep_dev_model i_sep_dev_model (.cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so));
   task automatic report_and_stop;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      // Read data stands through the access phase; take it at the ready edge
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         num_errors++;
         report_and_stop();
      end
   endtask
   task automatic run(input logic [3:0] op, input logic [11:0] a, input logic [31:0] d);
      int i;
      if (op == 4'h7) apb(12'h014, 1'b1, d);
      if (op > 4'h6) return;
      apb(12'h004, 1'b1, {20'h0, a});
      apb(12'h008, 1'b1, d);
      apb(12'h000, 1'b1, {18'h0, (op > 4'h4) ? 6'h03 : 6'h00, 4'h0, op[2:0], 1'b1});
      for (i = 0; i < 2000; i++) begin
         apb(12'h010, 1'b0, 32'h0);
         if (rv[0] === 1'b0) break;
      end
      if (i == 2000) begin
         num_errors++;
         report_and_stop();
      end
      apb(12'h00C, 1'b0, 32'h0);
   endtask
   initial begin
      int i;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      foreach (rows[k]) begin
         run(rows[k].op, rows[k].a, rows[k].d);
         for (i = 0; rows[k].op == 4'h8 && i < 20; i++) begin
            run(4'h3, 12'h000, 32'h0);
            if (rv[0] === 1'b0) break;
         end
         if (i == 20) chk("device busy poll", 32'h1, 32'h0);
         if (rows[k].op == 4'h3) chk("status", {24'h0, rv[7:0]}, rows[k].e);
         if (rows[k].op == 4'h5) chk("array", rv, rows[k].e);
      end
      apb(12'h014, 1'b1, 32'h0);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(negedge mclk);
      chk("pins after reset", {29'h0, cs_n, sck, wp_n}, 32'h5);
      chk("read data after reset", prdata, 32'h0);
      apb(12'h014, 1'b0, 32'h0);
      chk("wp control after reset", rv, 32'h1);
      apb(12'h018, 1'b0, 32'h0);
      chk("unmapped read", rv, 32'h0);
      report_and_stop();
   end
endmodule // sep_host_tb_top
bind sep_host sep_host_assertions i_sep_host_assertions (.mclk(mclk), .srst(srst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n));
